// >>> csp_pkg.sv
package csp_pkg;
    // register byte addresses
    localparam logic [7:0] CSP_ADDR_CTRL      = 8'h00;
    localparam logic [7:0] CSP_ADDR_STATUS    = 8'h04;
    localparam logic [7:0] CSP_ADDR_SETPOINT  = 8'h08;
    localparam logic [7:0] CSP_ADDR_YMAN      = 8'h0C;
    localparam logic [7:0] CSP_ADDR_DYMAN     = 8'h10;
    localparam logic [7:0] CSP_ADDR_REST      = 8'h14;
    localparam logic [7:0] CSP_ADDR_FAILY     = 8'h18;
    localparam logic [7:0] CSP_ADDR_TRACK     = 8'h1C;
    localparam logic [7:0] CSP_ADDR_Y         = 8'h20;
    localparam logic [7:0] CSP_ADDR_ALARM     = 8'h24;
    localparam logic [7:0] CSP_ADDR_DIO       = 8'h28;
    localparam logic [7:0] CSP_ADDR_FORCE_LO  = 8'h2C;
    localparam logic [7:0] CSP_ADDR_FORCE_MID = 8'h30;
    localparam logic [7:0] CSP_ADDR_FORCE_HI  = 8'h34;

    // control register fields
    localparam int CSP_C_TUNE    = 0;
    localparam int CSP_C_MANUAL  = 1;
    localparam int CSP_C_OFF     = 2;
    localparam int CSP_C_INC     = 3;
    localparam int CSP_C_DEC     = 4;
    localparam int CSP_C_SPEED   = 5;
    localparam int CSP_C_STEPPER = 6;
    localparam int CSP_C_PSET    = 7;
    localparam int CSP_C_WSEL    = 8;
    localparam int CSP_C_SCOFF   = 9;  // two bits
    localparam int CSP_C_FAILR   = 12; // three bits

    localparam logic [1:0]  CSP_SCOFF_HOST  = 2'h0;
    localparam logic [1:0]  CSP_SCOFF_PIN   = 2'h1;
    localparam logic [1:0]  CSP_SCOFF_FORCE = 2'h2;
    localparam logic [1:0]  CSP_SCOFF_INV   = 2'h3;
    localparam logic [2:0]  CSP_FAIL_IGNORE = 3'h6;
    localparam logic [15:0] CSP_SP_OFF      = 16'h8300; // -32000
    localparam logic [15:0] CSP_Y_ZERO      = 16'h0000;
    localparam logic [15:0] CSP_Y_FULL      = 16'h03E8; // 100.0 % in 0.1 % units
    localparam logic [15:0] CSP_Y_MAX       = 16'h041A; // 105.0 %
    localparam logic [15:0] CSP_Y_MIN       = 16'hFBE6; // -105.0 %

    localparam int CSP_CLK_HZ   = 40_000_000;
    localparam int CSP_REST_S   = 90;
    localparam int CSP_SLOW_S   = 40;
    localparam int CSP_FAST_S   = 20;
    // ninety seconds of clocks overflows a 32-bit int
    localparam longint CSP_REST_CYC = longint'(CSP_REST_S) * CSP_CLK_HZ;
    localparam int CSP_SLOW_CYC = CSP_SLOW_S * CSP_CLK_HZ / 1000;
    localparam int CSP_FAST_CYC = CSP_FAST_S * CSP_CLK_HZ / 1000;

    localparam logic [7:0] CSP_ALARM_FIXED = 8'h40;
    localparam logic [7:0] CSP_DIO_FIXED   = 8'h40;

    typedef enum {
        CSP_AUTO, CSP_TUNE_RUN, CSP_TUNE_ERR, CSP_SENSOR,
        CSP_MANUAL, CSP_TRACK, CSP_OFF
    } csp_mode_type;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } csp_wb_req_type;

    typedef struct packed {
        logic relay_one_state;
        logic relay_two_state;
        logic relay_three_state;
        logic output_short_alarm;
        logic heater_short_alarm;
        logic leakage_alarm;
        logic outputs_13_16_fail;
    } csp_alarm_in_type;

    function automatic logic csp_even_par(input logic [6:0] d);
        return ^d;
    endfunction : csp_even_par
endpackage : csp_pkg

// >>> csp_core.sv
`timescale 1ns/1ps
// Contract
// RQ1 - highest requested priority status wins
// RQ2 - tuning request 1 starts, 0 stops
// RQ3 - tuning running bit reads one
// RQ4 - higher status aborts tuning immediately
// RQ5 - setpoint writable; success returns to automatic
// RQ6 - tune from auto outputs rest value
// RQ7 - tune from manual keeps manual value
// RQ8 - rest after band held ninety seconds
// RQ9 - tune error: rest value, manual locked
// RQ10 - error held until request cleared
// RQ11 - sensor break outputs configured fail value
// RQ12 - leaving sensor break reinitialises controller
// RQ13 - fail reaction six ignores sensor break
// RQ14 - manual entry keeps last value
// RQ15 - manual takes absolute, differential, inc/dec
// RQ16 - ramp full scale 40 s or 20 s
// RQ17 - stepping controller refuses absolute value
// RQ18 - absolute manual value tracks output
// RQ19 - tracking drives output toward target
// RQ20 - switch-off source selection codes
// RQ21 - setpoint -32000 switches controller off
// RQ22 - off forces zero output, locks changes
// RQ23 - alarm byte bits zero to three; code carries alarm inputs on bits zero to four
// RQ24 - alarm bits four to seven fixed; code puts heater short alarm on bit four and parity on bit seven
// RQ25 - status parity is even over seven
module csp_core
    import csp_pkg::*;
#(
    parameter longint REST_CYCLES = CSP_REST_CYC,
    parameter int     SLOW_CYCLES = CSP_SLOW_CYC,
    parameter int     FAST_CYCLES = CSP_FAST_CYC
)(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire csp_wb_req_type   wb_req,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  wire csp_alarm_in_type alarm_in,
    input  wire logic             shared_io_fourteen,
    input  wire logic             sensor_break,
    input  wire logic             track_request,
    input  wire logic             tune_success,
    input  wire logic             tune_fail,
    input  wire logic             pv_in_band,
    input  wire logic [15:0]      auto_y,
    output logic [15:0]           y_out,
    output logic [2:0]            mode_out,
    output logic                  tune_status_bit,
    output logic                  ident_enable,
    output logic                  ctrl_reinit,
    output logic                  use_substitute,
    output logic                  force_enable,
    output logic [18:0]           forced_outputs
);
    initial begin
        if (REST_CYCLES < 1 || REST_CYCLES > 64'h0000_0000_FFFF_FFFE)
            $error("REST_CYCLES out of range");
        if (SLOW_CYCLES < 1 || FAST_CYCLES < 1) $error("ramp cycles must be positive");
    end

    typedef struct packed {
        logic [15:0]  ctrl;
        logic [15:0]  setpoint;
        logic [15:0]  dyman;
        logic         dyman_pend;
        logic [15:0]  yman_abs;
        logic         yman_pend;
        logic [15:0]  rest_correcting_value;
        logic [15:0]  fail_y;
        logic [15:0]  track_y;
        logic [15:0]  y;
        csp_mode_type mode;
        logic         tune_err;
        logic         at_rest;
        logic [31:0]  rest_cnt;
        logic [31:0]  ramp_cnt;
        logic [15:0]  force_lo;
        logic [15:0]  force_mid;
        logic [15:0]  force_hi;
        logic [1:0]   sync_pin_a;
        logic [1:0]   sync_pin_b;
        logic [7:0]   alarm_status;
        logic [7:0]   dio_status;
        logic         reinit;
        logic [31:0]  rdata;
        logic         ack;
    } csp_state_type;

    csp_state_type st_reg;
    csp_state_type st_next;

    logic        wr;
    logic        rd_sel;
    logic [7:0]  addr;
    logic        off_req;
    logic        man_req;
    logic        sens_req;
    logic        pin14;
    logic [1:0]  scoff;
    logic [31:0] ramp_limit;
    logic [6:0]  alarm_low;
    logic [6:0]  dio_low;
    csp_mode_type want;

    function automatic logic [15:0] csp_clamp(input logic signed [16:0] v);
        if (v > $signed({1'b0, CSP_Y_MAX}))
            return CSP_Y_MAX;
        else if (v < $signed({CSP_Y_MIN[15], CSP_Y_MIN}))
            return CSP_Y_MIN;
        return v[15:0];
    endfunction : csp_clamp

    always_comb begin
        st_next  = st_reg;
        addr     = wb_req.adr[7:0];
        wr       = wb_req.cyc && wb_req.stb && wb_req.we && !st_reg.ack;
        rd_sel   = wb_req.cyc && wb_req.stb && !st_reg.ack;
        scoff    = st_reg.ctrl[CSP_C_SCOFF +: 2];
        pin14    = st_reg.sync_pin_b[1];
        // off sources by selection code
        off_req  = st_reg.ctrl[CSP_C_OFF]
                   || (scoff == CSP_SCOFF_PIN && pin14)
                   || (scoff == CSP_SCOFF_INV && !pin14)
                   || (scoff == CSP_SCOFF_FORCE)
                   || (st_reg.setpoint == CSP_SP_OFF); // RQ20 RQ21
        sens_req = st_reg.sync_pin_a[1]
                   && (st_reg.ctrl[CSP_C_FAILR +: 3] != CSP_FAIL_IGNORE); // RQ13
        man_req  = st_reg.ctrl[CSP_C_MANUAL];
        ramp_limit = st_reg.ctrl[CSP_C_SPEED] ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES); // RQ16

        // synchronisers for pin-level inputs
        st_next.sync_pin_a = {st_reg.sync_pin_a[0], sensor_break};
        st_next.sync_pin_b = {st_reg.sync_pin_b[0], shared_io_fourteen};
        st_next.reinit     = 1'b0;
        st_next.ack        = wb_req.cyc && wb_req.stb && !st_reg.ack;

        // register writes
        if (wr) begin
            case (addr)
                CSP_ADDR_CTRL:      st_next.ctrl = wb_req.dat[15:0]; // RQ2
                CSP_ADDR_SETPOINT:  st_next.setpoint = wb_req.dat[15:0]; // RQ5
                CSP_ADDR_YMAN: begin
                    if (!st_reg.ctrl[CSP_C_STEPPER]) begin // RQ17
                        st_next.yman_abs  = wb_req.dat[15:0];
                        st_next.yman_pend = 1'b1;
                    end
                end
                CSP_ADDR_DYMAN: begin
                    st_next.dyman      = wb_req.dat[15:0];
                    st_next.dyman_pend = 1'b1;
                end
                CSP_ADDR_REST:      st_next.rest_correcting_value = wb_req.dat[15:0];
                CSP_ADDR_FAILY:     st_next.fail_y = wb_req.dat[15:0];
                CSP_ADDR_TRACK:     st_next.track_y = wb_req.dat[15:0];
                CSP_ADDR_FORCE_LO:  st_next.force_lo = {8'h00, wb_req.dat[7:0]};
                CSP_ADDR_FORCE_MID: st_next.force_mid = {8'h00, wb_req.dat[7:0]};
                CSP_ADDR_FORCE_HI:  st_next.force_hi = {13'h0000, wb_req.dat[2:0]};
                default: ;
            endcase
        end

        // process-at-rest watchdog, restarts on leaving band
        if (!pv_in_band || st_reg.mode != CSP_TUNE_RUN) begin
            st_next.rest_cnt = 32'h0000_0000;
            st_next.at_rest  = 1'b0;
        end else if (st_reg.rest_cnt < 32'(REST_CYCLES)) begin
            st_next.rest_cnt = st_reg.rest_cnt + 32'h0000_0001;
        end else begin
            st_next.at_rest = 1'b1; // RQ8
        end

        // error stays until the start request is cleared
        if (!st_next.ctrl[CSP_C_TUNE])
            st_next.tune_err = 1'b0; // RQ10
        if (st_reg.mode == CSP_TUNE_RUN && tune_fail)
            st_next.tune_err = 1'b1; // RQ9

        // fixed-priority arbitration
        if (off_req)
            want = CSP_OFF;
        else if (track_request)
            want = CSP_TRACK;
        else if (man_req)
            want = CSP_MANUAL;
        else if (sens_req)
            want = CSP_SENSOR;
        else if (st_next.tune_err)
            want = CSP_TUNE_ERR;
        else if (st_reg.ctrl[CSP_C_TUNE] && st_next.ctrl[CSP_C_TUNE]
                 && !(st_reg.mode == CSP_TUNE_RUN && tune_success)
                 && !(st_reg.mode == CSP_AUTO && st_reg.tune_err))
            want = CSP_TUNE_RUN; // RQ2 RQ4
        else
            want = CSP_AUTO; // RQ1 RQ5
        // success drops the request so tuning does not restart
        if (st_reg.mode == CSP_TUNE_RUN && tune_success)
            st_next.ctrl[CSP_C_TUNE] = 1'b0; // RQ5
        st_next.mode = want;

        if (st_reg.mode == CSP_SENSOR && want != CSP_SENSOR)
            st_next.reinit = 1'b1; // RQ12

        // correcting value per status
        st_next.ramp_cnt = st_reg.ramp_cnt + 32'h0000_0001;
        case (want)
            CSP_OFF: st_next.y = CSP_Y_ZERO; // RQ22
            CSP_TRACK: begin
                if (st_reg.ramp_cnt >= ramp_limit) begin
                    st_next.ramp_cnt = 32'h0000_0000;
                    if ($signed(st_reg.y) < $signed(st_reg.track_y))
                        st_next.y = st_reg.y + 16'h0001;
                    else if ($signed(st_reg.y) > $signed(st_reg.track_y))
                        st_next.y = st_reg.y - 16'h0001; // RQ19
                end
            end
            CSP_SENSOR: begin
                if (st_reg.mode != CSP_SENSOR)
                    st_next.y = st_reg.fail_y; // RQ11
                else if (st_reg.yman_pend)
                    st_next.y = csp_clamp(17'(signed'(st_reg.yman_abs)));
            end
            CSP_TUNE_ERR: st_next.y = st_reg.rest_correcting_value; // RQ9
            CSP_TUNE_RUN: begin
                if (st_reg.mode == CSP_AUTO)
                    st_next.y = st_reg.rest_correcting_value; // RQ6
            end
            CSP_MANUAL: begin
                // entry keeps y; only host adjustments move it
                if (st_reg.mode == CSP_MANUAL) begin // RQ14
                    if (st_reg.yman_pend)
                        st_next.y = csp_clamp(17'(signed'(st_reg.yman_abs))); // RQ15
                    else if (st_reg.dyman_pend)
                        st_next.y = csp_clamp(17'(signed'(st_reg.y))
                                              + 17'(signed'(st_reg.dyman)));
                    else if (st_reg.ramp_cnt >= ramp_limit) begin
                        st_next.ramp_cnt = 32'h0000_0000;
                        if (st_reg.ctrl[CSP_C_INC] && !st_reg.ctrl[CSP_C_DEC])
                            st_next.y = csp_clamp(17'(signed'(st_reg.y)) + 17'h0_0001);
                        else if (st_reg.ctrl[CSP_C_DEC] && !st_reg.ctrl[CSP_C_INC])
                            st_next.y = csp_clamp(17'(signed'(st_reg.y)) - 17'h0_0001); // RQ16
                    end
                end
            end
            default: st_next.y = auto_y;
        endcase
        // tuning from manual simply keeps the present value
        if (want == CSP_TUNE_RUN && st_reg.mode == CSP_MANUAL)
            st_next.y = st_reg.y; // RQ7
        if (want != CSP_MANUAL && want != CSP_TRACK)
            st_next.ramp_cnt = 32'h0000_0000;

        // pending adjustments are consumed or dropped once per cycle
        if (!(wr && addr == CSP_ADDR_YMAN))
            st_next.yman_pend = 1'b0;
        if (!(wr && addr == CSP_ADDR_DYMAN))
            st_next.dyman_pend = 1'b0;
        // absolute value mirrors the output unless just written
        if (!st_next.yman_pend)
            st_next.yman_abs = st_next.y; // RQ18

        // status bytes with even parity
        alarm_low = {1'b1, 1'b0, alarm_in.heater_short_alarm,
                     alarm_in.output_short_alarm, alarm_in.relay_three_state,
                     alarm_in.relay_two_state, alarm_in.relay_one_state}; // RQ23 RQ24
        st_next.alarm_status = {csp_even_par(alarm_low), alarm_low} | CSP_ALARM_FIXED; // RQ25
        dio_low = {1'b1, alarm_in.outputs_13_16_fail, 1'b0, alarm_in.leakage_alarm,
                   (want == CSP_OFF), st_reg.ctrl[CSP_C_WSEL], st_reg.ctrl[CSP_C_PSET]};
        st_next.dio_status = {csp_even_par(dio_low), dio_low} | CSP_DIO_FIXED; // RQ25

        // read mux
        st_next.rdata = 32'h0000_0000;
        if (rd_sel) begin
            case (addr)
                CSP_ADDR_CTRL:      st_next.rdata = {16'h0000, st_reg.ctrl};
                CSP_ADDR_STATUS:    st_next.rdata = {27'h000_0000,
                                                     (st_reg.mode == CSP_TUNE_RUN),
                                                     st_reg.at_rest,
                                                     3'(st_reg.mode)}; // RQ3
                CSP_ADDR_SETPOINT:  st_next.rdata = {16'h0000, st_reg.setpoint};
                CSP_ADDR_YMAN:      st_next.rdata = {16'h0000, st_reg.yman_abs};
                CSP_ADDR_DYMAN:     st_next.rdata = {16'h0000, st_reg.dyman};
                CSP_ADDR_REST:      st_next.rdata = {16'h0000, st_reg.rest_correcting_value};
                CSP_ADDR_FAILY:     st_next.rdata = {16'h0000, st_reg.fail_y};
                CSP_ADDR_TRACK:     st_next.rdata = {16'h0000, st_reg.track_y};
                CSP_ADDR_Y:         st_next.rdata = {16'h0000, st_reg.y};
                CSP_ADDR_ALARM:     st_next.rdata = {24'h00_0000, st_reg.alarm_status};
                CSP_ADDR_DIO:       st_next.rdata = {24'h00_0000, st_reg.dio_status};
                CSP_ADDR_FORCE_LO:  st_next.rdata = {16'h0000, st_reg.force_lo};
                CSP_ADDR_FORCE_MID: st_next.rdata = {16'h0000, st_reg.force_mid};
                CSP_ADDR_FORCE_HI:  st_next.rdata = {16'h0000, st_reg.force_hi};
                default:            st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg      <= '0;
            st_reg.mode <= CSP_AUTO;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o        = st_reg.rdata;
    assign wb_ack_o        = st_reg.ack;
    assign y_out           = st_reg.y;
    assign mode_out        = 3'(st_reg.mode);
    assign tune_status_bit = (st_reg.mode == CSP_TUNE_RUN); // RQ3
    assign ident_enable    = st_reg.at_rest;
    assign ctrl_reinit     = st_reg.reinit;
    assign use_substitute  = (st_reg.ctrl[CSP_C_FAILR +: 3] == CSP_FAIL_IGNORE); // RQ13
    // forcing follows the permanent-off code, rising one cycle before the off status
    assign force_enable    = (st_reg.ctrl[CSP_C_SCOFF +: 2] == CSP_SCOFF_FORCE); // RQ20
    assign forced_outputs  = {st_reg.force_hi[2:0], st_reg.force_mid[7:0],
                              st_reg.force_lo[7:0]};
endmodule : csp_core

// >>> csp_core_props.sv
`timescale 1ns/1ps
module csp_core_props
    import csp_pkg::*;
#(
    parameter longint REST_CYCLES = CSP_REST_CYC
)(
    input wire logic             clk,
    input wire logic             arst_n,
    input wire csp_wb_req_type   wb_req,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire csp_alarm_in_type alarm_in,
    input wire logic             track_request,
    input wire logic             pv_in_band,
    input wire logic [15:0]      y_out,
    input wire logic [2:0]       mode_out,
    input wire logic             tune_status_bit,
    input wire logic             ident_enable,
    input wire logic             ctrl_reinit,
    input wire logic             force_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    int         band_reg;
    logic [6:0] alarm_low;
    assign alarm_low = {2'h2, alarm_in.heater_short_alarm, alarm_in.output_short_alarm,
                        alarm_in.relay_three_state, alarm_in.relay_two_state,
                        alarm_in.relay_one_state};
    // run length of the band flag, restarts on every excursion
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            band_reg <= 0;
        end else begin
            band_reg <= pv_in_band ? band_reg + 1 : 0;
        end
    end
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_ack_o;
    endsequence
    sequence s_alarm_read;
        s_take ##0 (!wb_req.we && wb_req.adr[7:0] == CSP_ADDR_ALARM) ##1 wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle after take");
    a_alarm_byte: assert property (
        s_alarm_read |-> wb_dat_o[7:0] == {^$past(alarm_low), $past(alarm_low)})
        else $error("alarm status byte wrong");
    a_tune_bit: assert property (tune_status_bit == (mode_out == 3'h1))
        else $error("tuning bit disagrees with status");
    a_off_zero: assert property (
        mode_out == 3'h6 && $past(mode_out) == 3'h6 |-> y_out == 16'h0000)
        else $error("output not zero while off");
    a_track_wins: assert property (
        track_request && $past(track_request) && mode_out != 3'h6 |-> mode_out == 3'h5)
        else $error("tracking request lost to lower status");
    a_force_off: assert property (force_enable |-> mode_out == 3'h6)
        else $error("output forcing outside off status");
    a_ident_rest: assert property (
        $rose(ident_enable) |-> mode_out == 3'h1 && $past(band_reg) >= REST_CYCLES - 2)
        else $error("rest declared too early");
    a_reinit_exit: assert property (
        (mode_out == 3'h3 ##1 mode_out != 3'h3) |-> ##[0:1] ctrl_reinit)
        else $error("no reinit after sensor status");
    a_reinit_pulse: assert property (ctrl_reinit |=> !ctrl_reinit)
        else $error("reinit longer than one cycle");
endmodule : csp_core_props

bind csp_core csp_core_props #(.REST_CYCLES(REST_CYCLES)) u_props (
    .clk, .arst_n, .wb_req, .wb_dat_o, .wb_ack_o, .alarm_in, .track_request,
    .pv_in_band, .y_out, .mode_out, .tune_status_bit, .ident_enable, .ctrl_reinit,
    .force_enable
);

// >>> csp_host.sv
`timescale 1ns/1ps
module csp_host
    import csp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output csp_wb_req_type   req
);
    initial req = '0;
    // request held until the edge that samples ack high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        req <= '{{24'h00_0000, a}, d, 4'hF, w, 1'h1, 1'h1};
        do @(posedge clk); while (ack !== 1'h1);
        q = rdat;
        req <= '0;
        @(posedge clk);
    endtask : xfer
endmodule : csp_host

// >>> csp_tb.sv
`timescale 1ns/1ps
module testbench
    import csp_pkg::*;
;
    localparam int    REST = 20;
    localparam int    SLOW = 1600;
    localparam int    FAST = 800;
    logic             clk = 1'h0;
    logic             arst_n = 1'h0;
    csp_wb_req_type   wb_req;
    csp_alarm_in_type alarm_in = '0;
    logic [31:0]      wb_dat_o, q;
    logic             wb_ack_o, tune_status_bit, ident_enable, ctrl_reinit;
    logic             use_substitute, force_enable;
    logic [15:0]      y_out;
    logic [15:0]      auto_y = 16'h0123;
    logic [2:0]       mode_out;
    logic [18:0]      forced_outputs;
    logic             shared_io_fourteen = 1'h0, sensor_break = 1'h0, track_request = 1'h0;
    logic             tune_success = 1'h0, tune_fail = 1'h0, pv_in_band = 1'h0;
    int               n_errors = 0, total_checks = 0;

    csp_core #(.REST_CYCLES(REST), .SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) dut (
        .clk, .arst_n, .wb_req, .wb_dat_o, .wb_ack_o, .alarm_in, .shared_io_fourteen,
        .sensor_break, .track_request, .tune_success, .tune_fail, .pv_in_band, .auto_y,
        .y_out, .mode_out, .tune_status_bit, .ident_enable, .ctrl_reinit, .use_substitute,
        .force_enable, .forced_outputs
    );
    csp_host host (.clk, .ack(wb_ack_o), .rdat(wb_dat_o), .req(wb_req));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic wr(logic [7:0] a, logic [31:0] d);
        host.xfer(1'h1, a, d, q);
    endtask : wr
    task automatic rd(logic [7:0] a);
        host.xfer(1'h0, a, 32'h0000_0000, q);
    endtask : rd
    task automatic st(logic [2:0] m, logic [15:0] y);
        cmp("mode", m, mode_out);
        cmp("y", y, y_out);
    endtask : st
    function automatic logic [7:0] par(logic [6:0] v);
        return {^v, v};
    endfunction : par

    task automatic t_regs;
        logic [6:0] p;
        st(3'h0, 16'h0123);
        for (int i = 0; i < 2; i++) begin
            p = i ? 7'h2A : 7'h55;
            @(posedge clk);
            alarm_in <= p;
            rd(CSP_ADDR_ALARM);
            cmp("alarm", par({2'h2, p[2], p[3], p[4], p[5], p[6]}), q);
            rd(CSP_ADDR_DIO);
            cmp("dio", par({1'h1, p[0], 1'h0, p[1], 3'h0}), q);
        end
        rd(8'hFC);
        cmp("unmapped", 32'h0000_0000, q);
        for (int i = 0; i < 3; i++) begin
            wr(CSP_ADDR_FORCE_LO + 8'(4 * i), 32'h0000_FFFF);
            rd(CSP_ADDR_FORCE_LO + 8'(4 * i));
            cmp("forced", (i == 2) ? 32'h0000_0007 : 32'h0000_00FF, q);
        end
        cmp("fout", 32'h0007_FFFF, {13'h0000, forced_outputs});
        $display("test regs done");
    endtask : t_regs

    task automatic t_manual;
        int s, d;
        logic [15:0] b;
        wr(CSP_ADDR_CTRL, 32'h0000_0002);
        auto_y <= 16'h0300;
        tick(3);
        st(3'h4, 16'h0123);
        rd(CSP_ADDR_YMAN);
        cmp("yman", 32'h0000_0123, q);
        wr(CSP_ADDR_YMAN, 32'h0000_0200);
        st(3'h4, 16'h0200);
        wr(CSP_ADDR_DYMAN, 32'h0000_0010);
        st(3'h4, 16'h0210);
        wr(CSP_ADDR_CTRL, 32'h0000_0042);
        wr(CSP_ADDR_YMAN, 32'h0000_0050);
        st(3'h4, 16'h0210);
        for (int f = 0; f < 2; f++) begin
            wr(CSP_ADDR_CTRL, 32'h0000_000A | (f << 5));
            b = y_out;
            tick(3600);
            s = f ? FAST : SLOW;
            d = int'(y_out - b);
            cmp("ramp", 1, d >= 3600 / s && d <= 3600 / s + 1);
        end
        wr(CSP_ADDR_CTRL, 32'h0000_0000);
        $display("test manual done");
    endtask : t_manual

    task automatic t_tune;
        wr(CSP_ADDR_REST, 32'h0000_00C8);
        wr(CSP_ADDR_CTRL, 32'h0000_0001);
        st(3'h1, 16'h00C8);
        cmp("tuning", 1, tune_status_bit);
        wr(CSP_ADDR_SETPOINT, 32'h0000_0100);
        cmp("mode", 3'h1, mode_out);
        pv_in_band <= 1'h1;
        tick(REST / 2);
        cmp("rest", 0, ident_enable);
        tick(REST);
        cmp("rest", 1, ident_enable);
        tune_success <= 1'h1;
        @(posedge clk);
        tune_success <= 1'h0;
        pv_in_band <= 1'h0;
        tick(2);
        cmp("mode", 3'h0, mode_out);
        wr(CSP_ADDR_CTRL, 32'h0000_0001);
        tune_fail <= 1'h1;
        @(posedge clk);
        tune_fail <= 1'h0;
        tick(2);
        st(3'h2, 16'h00C8);
        wr(CSP_ADDR_YMAN, 32'h0000_0300);
        st(3'h2, 16'h00C8);
        wr(CSP_ADDR_CTRL, 32'h0000_0000);
        cmp("mode", 3'h0, mode_out);
        wr(CSP_ADDR_CTRL, 32'h0000_0001);
        wr(CSP_ADDR_CTRL, 32'h0000_0003);
        cmp("mode", 3'h4, mode_out);
        wr(CSP_ADDR_CTRL, 32'h0000_0000);
        $display("test tune done");
    endtask : t_tune

    task automatic t_sensor;
        int seen;
        wr(CSP_ADDR_FAILY, 32'h0000_0064);
        sensor_break <= 1'h1;
        tick(5);
        st(3'h3, 16'h0064);
        sensor_break <= 1'h0;
        seen = 0;
        repeat (6) begin
            @(posedge clk);
            seen += (ctrl_reinit === 1'h1);
        end
        cmp("reinit", 1, seen);
        wr(CSP_ADDR_CTRL, 32'h0000_6000);
        sensor_break <= 1'h1;
        tick(5);
        cmp("mode", 3'h0, mode_out);
        cmp("subst", 1, use_substitute);
        sensor_break <= 1'h0;
        wr(CSP_ADDR_CTRL, 32'h0000_0000);
        $display("test sensor done");
    endtask : t_sensor

    task automatic t_off;
        logic off;
        track_request <= 1'h1;
        wr(CSP_ADDR_CTRL, 32'h0000_0002);
        cmp("mode", 3'h5, mode_out);
        wr(CSP_ADDR_CTRL, 32'h0000_0006);
        wr(CSP_ADDR_YMAN, 32'h0000_0100);
        st(3'h6, 16'h0000);
        track_request <= 1'h0;
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 2; p++) begin
                shared_io_fourteen <= p[0];
                wr(CSP_ADDR_CTRL, 32'(c) << 9);
                tick(4);
                off = c == 2 || (c == 1 && p == 1) || (c == 3 && p == 0);
                cmp("mode", off ? 3'h6 : 3'h0, mode_out);
                cmp("force", c == 2, force_enable);
            end
        end
        wr(CSP_ADDR_CTRL, 32'h0000_0000);
        wr(CSP_ADDR_SETPOINT, {16'h0000, CSP_SP_OFF});
        cmp("mode", 3'h6, mode_out);
        wr(CSP_ADDR_SETPOINT, 32'h0000_0100);
        cmp("mode", 3'h0, mode_out);
        $display("test off done");
    endtask : t_off

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    initial begin
        tick(16);
        arst_n <= 1'h1;
        tick(3);
        t_regs();
        t_manual();
        t_tune();
        t_sensor();
        t_off();
        close_out();
    end
    // whole run is near 7500 cycles
    initial begin
        tick(40000);
        n_errors++;
        close_out();
    end
endmodule : testbench
